// *** rtl/gt_regs.svh ***
// Register offsets, field positions, reset values and clock periods of the gated timer.
// Assumes a 5-bit AXI4-Lite byte address and a 50 MHz system clock.
`ifndef GT_REGS_SVH
`define GT_REGS_SVH

// ==========================================================================
// Register byte offsets
`define GT_OFF_COUNT      5'h00
`define GT_OFF_CONTROL    5'h04
`define GT_OFF_GATE       5'h08
`define GT_OFF_IRQ_STATUS 5'h0C
`define GT_OFF_IRQ_MASK   5'h10

// ==========================================================================
// Field positions
`define GT_CTL_CLKSEL_LO  0
`define GT_CTL_CLKSEL_HI  1
`define GT_CTL_SYNC       2
`define GT_CTL_RUN        3
`define GT_GATE_ENABLE    0
`define GT_GATE_POL       1
`define GT_GATE_TOGGLE    2
`define GT_GATE_SRC_LO    3
`define GT_GATE_SRC_HI    4
`define GT_GATE_LEVEL     5
`define GT_IRQ_OVF        0

// ==========================================================================
// Encodings and reset values
`define GT_CLK_INSN       2'h0
`define GT_CLK_SYS        2'h1
`define GT_CLK_EXT        2'h2
`define GT_SRC_PIN        2'h0
`define GT_SRC_BYTE       2'h1
`define GT_SRC_PERIOD     2'h2
`define GT_SRC_NONE       2'h3
`define GT_CMP_SPECIAL    4'hB
`define GT_COUNT_MAX      16'hFFFF
`define GT_RST_COUNT      16'h0000
`define GT_RST_CLKSEL     2'h0
`define GT_RESP_OKAY      2'h0
`define GT_RESP_SLVERR    2'h2

// ==========================================================================
// Timing
`define GT_CLK_PERIOD_NS  20
`define GT_INSN_PERIOD_NS 80

`endif

// *** rtl/gt_pkg.sv ***
// Types of the gated timer: its complete state record.
// Assumes gt_regs.svh for the field widths used here.
package gt_pkg;
  `include "gt_regs.svh"

  typedef struct packed {
    logic [15:0] count;
    logic        flag;
    logic        ie;
    logic [1:0]  clksel;
    logic        sync;
    logic        run;
    logic        ge;
    logic        pol;
    logic        tm;
    logic [1:0]  gss;
    logic        tff;
    logic        gate_prev;
    logic [2:0]  presc;
    logic [2:0]  pin_sync;
    logic        pin_lvl;
    logic [2:0]  ext_sync;
    logic        ext_lvl;
    logic        bw_smp;
    logic        pm_smp;
    logic [2:0]  bstr;
    logic [2:0]  pstr;
    logic        aw_got;
    logic [4:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;
endpackage

// *** rtl/gated_timer.sv ***
// Gated 16-bit up-counter with overflow interrupt, compare-trigger reset and gate logic.
// Assumes an AXI4-Lite master on CLOCK_I; gate pulses from neighbour timers on the same clock.
`timescale 1ns/1ps
`include "gt_regs.svh"

module gated_timer (
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [4:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output      logic        S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output      logic        S_AXI_WREADY_O,
  output      logic [1:0]  S_AXI_BRESP_O,
  output      logic        S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [4:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output      logic        S_AXI_ARREADY_O,
  output      logic [31:0] S_AXI_RDATA_O,
  output      logic [1:0]  S_AXI_RRESP_O,
  output      logic        S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        GATE_PIN_I,
  input  wire logic        EXT_CLOCK_PIN_I,
  input  wire logic        BYTE_TIMER_WRAP_I,
  input  wire logic        PERIOD_RESET_I,
  input  wire logic [7:0]  COMPARE_UNIT_MODE_I,
  input  wire logic [1:0]  COMPARE_MATCH_I,
  input  wire logic [1:0]  COMPARE_ASSIGNED_I,
  output      logic        IRQ_O
);

  localparam logic [2:0] INSN_CYC = 3'(`GT_INSN_PERIOD_NS / `GT_CLK_PERIOD_NS);

  gt_pkg::state_t s_reg;
  gt_pkg::state_t s_next;

  logic        tick;
  logic        ext_rise;
  logic        gate_src;
  logic        gate_pol_sig;
  logic        gate_val;
  logic        count_en;
  logic        trig;
  logic        trig_ok;
  logic        do_wr;
  logic        wr_cnt;
  logic [15:0] wr_val;
  logic        wrap;
  logic [4:0]  wa;
  logic [4:0]  ra;

  // ==========================================================================
  // Handshakes
  assign S_AXI_AWREADY_O = !s_reg.aw_got && !s_reg.bvalid;
  assign S_AXI_WREADY_O  = !s_reg.w_got && !s_reg.bvalid;
  assign S_AXI_ARREADY_O = !s_reg.rvalid;
  assign S_AXI_BVALID_O  = s_reg.bvalid;
  assign S_AXI_BRESP_O   = s_reg.bresp;
  assign S_AXI_RVALID_O  = s_reg.rvalid;
  assign S_AXI_RDATA_O   = s_reg.rdata;
  assign S_AXI_RRESP_O   = s_reg.rresp;
  assign IRQ_O           = s_reg.flag && s_reg.ie;

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    // Pins pass three flops; a level counts once the last two agree
    s_next.pin_sync = {s_reg.pin_sync[1:0], GATE_PIN_I};
    s_next.ext_sync = {s_reg.ext_sync[1:0], EXT_CLOCK_PIN_I};
    if (s_reg.pin_sync[1] == s_reg.pin_sync[2])
    begin
      s_next.pin_lvl = s_reg.pin_sync[2];
    end
    ext_rise = (s_reg.ext_sync[1] == s_reg.ext_sync[2]) && s_reg.ext_sync[2] && !s_reg.ext_lvl;
    if (s_reg.ext_sync[1] == s_reg.ext_sync[2])
    begin
      s_next.ext_lvl = s_reg.ext_sync[2];
    end

    // Instruction clock is one quarter of the system clock
    if (s_reg.presc == INSN_CYC - 3'h1)
    begin
      s_next.presc = 3'h0;
    end
    else
    begin
      s_next.presc = s_reg.presc + 3'h1;
    end
    case (s_reg.clksel)
      `GT_CLK_SYS:  tick = 1'b1;
      `GT_CLK_INSN: tick = (s_reg.presc == INSN_CYC - 3'h1);
      `GT_CLK_EXT:  tick = ext_rise;
      default:      tick = 1'b0;
    endcase

    // Internal pulses are registered, then stretched to one instruction cycle
    s_next.bw_smp = BYTE_TIMER_WRAP_I;
    s_next.pm_smp = PERIOD_RESET_I;
    if (s_reg.bw_smp)
    begin
      s_next.bstr = INSN_CYC;
    end
    else if (s_reg.bstr != 3'h0)
    begin
      s_next.bstr = s_reg.bstr - 3'h1;
    end
    if (s_reg.pm_smp)
    begin
      s_next.pstr = INSN_CYC;
    end
    else if (s_reg.pstr != 3'h0)
    begin
      s_next.pstr = s_reg.pstr - 3'h1;
    end

    // Gate chain: source, polarity, toggle
    case (s_reg.gss)
      `GT_SRC_PIN:    gate_src = s_reg.pin_lvl;
      `GT_SRC_BYTE:   gate_src = (s_reg.bstr != 3'h0);
      `GT_SRC_PERIOD: gate_src = (s_reg.pstr != 3'h0);
      default:        gate_src = 1'b0;
    endcase
    gate_pol_sig = s_reg.pol ? gate_src : !gate_src;
    if (s_reg.gss == `GT_SRC_NONE)
    begin
      gate_pol_sig = 1'b0;
    end
    s_next.gate_prev = gate_pol_sig;
    if (!s_reg.tm)
    begin
      s_next.tff = 1'b0;
    end
    else if (gate_pol_sig && !s_reg.gate_prev)
    begin
      s_next.tff = !s_reg.tff;
    end
    gate_val = s_reg.tm ? s_reg.tff : gate_pol_sig;
    count_en = s_reg.run && tick && (!s_reg.ge || gate_val);

    // Compare trigger; an unsynchronised external count cannot be cleared reliably
    trig = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      if (COMPARE_MATCH_I[i] && COMPARE_ASSIGNED_I[i] &&
          COMPARE_UNIT_MODE_I[4*i +: 4] == `GT_CMP_SPECIAL)
      begin
        trig = 1'b1;
      end
    end
    trig_ok = trig && !(s_reg.clksel == `GT_CLK_EXT && !s_reg.sync);

    // Register write, performed once address and data are both held
    do_wr  = s_reg.aw_got && s_reg.w_got;
    wa     = {s_reg.aw_addr[4:2], 2'b00};
    wr_cnt = do_wr && (wa == `GT_OFF_COUNT);
    wr_val = {s_reg.w_strb[1] ? s_reg.w_data[15:8] : s_reg.count[15:8],
              s_reg.w_strb[0] ? s_reg.w_data[7:0]  : s_reg.count[7:0]};
    wrap   = 1'b0;

    if (wr_cnt)
    begin
      s_next.count = wr_val;
    end
    else if (trig_ok)
    begin
      s_next.count = `GT_RST_COUNT;
    end
    else if (count_en)
    begin
      s_next.count = 16'(s_reg.count + 16'h0001);
      wrap = (s_reg.count == `GT_COUNT_MAX);
    end

    if (do_wr)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = `GT_RESP_OKAY;
      case (wa)
        `GT_OFF_COUNT: ;
        `GT_OFF_CONTROL:
        begin
          if (s_reg.w_strb[0])
          begin
            s_next.clksel = s_reg.w_data[`GT_CTL_CLKSEL_HI:`GT_CTL_CLKSEL_LO];
            s_next.sync   = s_reg.w_data[`GT_CTL_SYNC];
            s_next.run    = s_reg.w_data[`GT_CTL_RUN];
          end
        end
        `GT_OFF_GATE:
        begin
          if (s_reg.w_strb[0])
          begin
            s_next.ge  = s_reg.w_data[`GT_GATE_ENABLE];
            s_next.pol = s_reg.w_data[`GT_GATE_POL];
            s_next.tm  = s_reg.w_data[`GT_GATE_TOGGLE];
            s_next.gss = s_reg.w_data[`GT_GATE_SRC_HI:`GT_GATE_SRC_LO];
          end
        end
        `GT_OFF_IRQ_STATUS:
        begin
          if (s_reg.w_strb[0] && s_reg.w_data[`GT_IRQ_OVF])
          begin
            s_next.flag = 1'b0;
          end
        end
        `GT_OFF_IRQ_MASK:
        begin
          if (s_reg.w_strb[0])
          begin
            s_next.ie = s_reg.w_data[`GT_IRQ_OVF];
          end
        end
        default: s_next.bresp = `GT_RESP_SLVERR;
      endcase
    end
    // A wrap in the clearing cycle still leaves the flag set
    if (wrap)
    begin
      s_next.flag = 1'b1;
    end

    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
    begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O)
    begin
      s_next.w_got  = 1'b1;
      s_next.w_data = S_AXI_WDATA_I;
      s_next.w_strb = S_AXI_WSTRB_I;
    end
    if (s_reg.bvalid && S_AXI_BREADY_I)
    begin
      s_next.bvalid = 1'b0;
    end

    // Read: data is captured at acceptance and held until taken
    ra = {S_AXI_ARADDR_I[4:2], 2'b00};
    if (s_reg.rvalid && S_AXI_RREADY_I)
    begin
      s_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `GT_RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      case (ra)
        `GT_OFF_COUNT:   s_next.rdata[15:0] = s_reg.count;
        `GT_OFF_CONTROL:
        begin
          s_next.rdata[`GT_CTL_CLKSEL_HI:`GT_CTL_CLKSEL_LO] = s_reg.clksel;
          s_next.rdata[`GT_CTL_SYNC] = s_reg.sync;
          s_next.rdata[`GT_CTL_RUN]  = s_reg.run;
        end
        `GT_OFF_GATE:
        begin
          s_next.rdata[`GT_GATE_ENABLE] = s_reg.ge;
          s_next.rdata[`GT_GATE_POL]    = s_reg.pol;
          s_next.rdata[`GT_GATE_TOGGLE] = s_reg.tm;
          s_next.rdata[`GT_GATE_SRC_HI:`GT_GATE_SRC_LO] = s_reg.gss;
          s_next.rdata[`GT_GATE_LEVEL]  = gate_val;
        end
        `GT_OFF_IRQ_STATUS: s_next.rdata[`GT_IRQ_OVF] = s_reg.flag;
        `GT_OFF_IRQ_MASK:   s_next.rdata[`GT_IRQ_OVF] = s_reg.ie;
        default:            s_next.rresp = `GT_RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      s_reg        <= '0;
      s_reg.count  <= `GT_RST_COUNT;
      s_reg.clksel <= `GT_RST_CLKSEL;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence pulse_taken_s;
    s_reg.pm_smp && (s_reg.pstr == 3'h0);
  endsequence

  sequence pulse_held_s;
    (s_reg.pstr != 3'h0) [*4] ##1 (s_reg.pstr == 3'h0 || $past(s_reg.pm_smp));
  endsequence

  wrap_sets_flag_a: assert property (
    count_en && !wr_cnt && !trig_ok && s_reg.count == 16'hFFFF
    |=> s_reg.count == 16'h0000 && s_reg.flag)
    else $error("wrap did not clear count and set flag");

  irq_follows_a: assert property (
    s_reg.flag && s_reg.ie |-> IRQ_O ##1 (IRQ_O || $past(do_wr)))
    else $error("interrupt not raised for enabled overflow");

  trig_clears_a: assert property (
    trig_ok && !wr_cnt |=> s_reg.count == 16'h0000)
    else $error("trigger did not clear count");

  async_ignore_a: assert property (
    trig && s_reg.clksel == 2'h2 && !s_reg.sync && !wr_cnt && !count_en
    |=> $stable(s_reg.count))
    else $error("trigger acted in asynchronous counter mode");

  write_wins_a: assert property (
    wr_cnt && trig_ok |=> s_reg.count == $past(wr_val))
    else $error("trigger overrode count write");

  trig_noflag_a: assert property (
    trig_ok && !wr_cnt && !s_reg.flag |=> !s_reg.flag)
    else $error("trigger reset set overflow flag");

  gate_hold_a: assert property (
    s_reg.ge && !gate_val && !wr_cnt && !trig_ok |=> $stable(s_reg.count))
    else $error("count moved while gate inactive");

  toggle_clear_a: assert property (
    !s_reg.tm |=> !s_reg.tff)
    else $error("toggle flop not held clear");

  period_pulse_a: assert property (
    pulse_taken_s |=> pulse_held_s)
    else $error("period gate pulse not one instruction cycle");

  none_source_a: assert property (
    s_reg.gss == 2'h3 && !s_reg.tm && s_reg.ge && !wr_cnt && !trig_ok
    |=> s_reg.count == $past(s_reg.count))
    else $error("count moved with inactive source code");

endmodule // gated_timer

// *** verif/gate_neighbours.sv ***
// Neighbour timers that feed the gate: byte timer wrap pulses and period-timer reset pulses.
// Assumes the gated timer's clock and synchronous active-high reset.
`timescale 1ns/1ps
module gate_neighbours #(
  parameter int PERIOD_LIMIT = 15
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output      logic byte_wrap_o,
  output      logic period_reset_o
);
  logic [7:0] byte_reg;
  logic [7:0] period_reg;

  // ==========================================================================
  // Free-running counters, one-cycle pulses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      byte_reg       <= 8'h00;
      period_reg     <= 8'h00;
      byte_wrap_o    <= 1'b0;
      period_reset_o <= 1'b0;
    end
    else
    begin
      byte_reg       <= byte_reg + 8'h01;
      byte_wrap_o    <= (byte_reg == 8'hFF);
      // Reset follows the match by one cycle, as the period timer does
      period_reg     <= (period_reg == 8'(PERIOD_LIMIT)) ? 8'h00 : period_reg + 8'h01;
      period_reset_o <= (period_reg == 8'(PERIOD_LIMIT));
    end
  end
endmodule  // gate_neighbours

// *** verif/gated_sixteen_bit_timer_tb.sv ***
// Self-checking bench of the gated timer: bus tasks, integer model, gate and trigger cases.
// Assumes gt_regs.svh on the include path and gate_neighbours as the far side.
`timescale 1ns/1ps
`include "gt_regs.svh"
module gated_sixteen_bit_timer_tb;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, gate_pin, ext_pin, byte_wrap, period_rst, irq;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0]  bresp, rresp, rsp, cmp_match, cmp_assign;
  logic [7:0]  cmp_mode;
  int          bad_count, n_checks, cyc, t_done, seed, d, n, e;
  // Gate setting, clock select, expected rate per 256 cycles, tolerance
  logic [31:0] cg [10] = '{32'h00, 32'h00, 32'h01, 32'h03, 32'h19, 32'h1B, 32'h0B, 32'h09,
                           32'h13, 32'h11};
  logic [1:0]  cs [10] = '{2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1};
  int          cn [10] = '{256, 64, 0, 256, 0, 0, 4, 252, 64, 192};
  int          ct [10] = '{1, 2, 0, 1, 0, 0, 5, 5, 5, 5};

  gated_timer dut_u (
    .CLOCK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .GATE_PIN_I(gate_pin), .EXT_CLOCK_PIN_I(ext_pin), .BYTE_TIMER_WRAP_I(byte_wrap),
    .PERIOD_RESET_I(period_rst), .COMPARE_UNIT_MODE_I(cmp_mode), .COMPARE_MATCH_I(cmp_match),
    .COMPARE_ASSIGNED_I(cmp_assign), .IRQ_O(irq));

  gate_neighbours nb_u (.clk_i(clk), .rst_i(rst), .byte_wrap_o(byte_wrap),
                        .period_reset_o(period_rst));

  // ==========================================================================
  // Clock, timeout, verdict
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================================================
  // Bus master; an optional compare match lands on the edge the write acts
  task automatic wr(input logic [4:0] a, input logic [31:0] dv, input logic trig = 1'b0);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dv;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    cmp_match <= {1'b0, trig};
    do
    begin
      @(posedge clk);
      cmp_match <= 2'b00;
    end
    while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
    t_done = cyc;
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd_val = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pin_pulse(input logic ext);
    @(posedge clk);
    if (ext) ext_pin <= 1'b1; else gate_pin <= 1'b1;
    repeat (6) @(posedge clk);
    if (ext) ext_pin <= 1'b0; else gate_pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic trig_pulse(input logic [1:0] m);
    @(posedge clk);
    cmp_match <= m;
    @(posedge clk);
    cmp_match <= 2'b00;
    repeat (3) @(posedge clk);
  endtask

  // Counts over a run window; the window is measured between the two write answers
  task automatic meas(input logic [31:0] g, input logic [1:0] sel);
    int t0;
    wr(`GT_OFF_COUNT, 32'h0);
    wr(`GT_OFF_GATE, g);
    wr(`GT_OFF_CONTROL, {28'h0, 2'b11, sel});
    t0 = t_done;
    repeat (1024) @(posedge clk);
    wr(`GT_OFF_CONTROL, 32'h4);
    d = t_done - t0;
    rd(`GT_OFF_COUNT);
    // An unknown count must not slip through as zero
    n = $isunknown(rd_val) ? -1 : int'(rd_val);
  endtask

  // ==========================================================================
  // Scenarios
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, ext_pin, awaddr, araddr, wdata} = '0;
    {cmp_match, bad_count, n_checks} = '0;
    gate_pin = 1'b1;
    cmp_mode = 8'hBB;
    cmp_assign = 2'b11;
    seed = 32'h95CCC9A5;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    for (int a = 0; a < 5; a++)
    begin
      rd(5'(a * 4));
      chk(rd_val, 32'h0);
    end
    rd(5'h14);
    chk({30'h0, rsp}, {30'h0, `GT_RESP_SLVERR});
    wr(5'h18, 32'hFFFFFFFF);
    chk({30'h0, rsp}, {30'h0, `GT_RESP_SLVERR});
    repeat (4)
    begin
      e = $random(seed);
      wr(`GT_OFF_COUNT, 32'(e));
      rd(`GT_OFF_COUNT);
      chk(rd_val, 32'(e) & 32'hFFFF);
    end
    // Wrap, flag and mask
    wr(`GT_OFF_COUNT, 32'hFFFD);
    wr(`GT_OFF_CONTROL, 32'hD);
    e = t_done;
    repeat (8) @(posedge clk);
    wr(`GT_OFF_CONTROL, 32'h4);
    rd(`GT_OFF_COUNT);
    chk(rd_val, (32'hFFFD + 32'(t_done - e)) & 32'hFFFF);
    rd(`GT_OFF_IRQ_STATUS);
    chk(rd_val, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`GT_OFF_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(`GT_OFF_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      meas(cg[i], cs[i]);
      e = d * cn[i] / 256;
      chk({31'h0, (n >= e - ct[i]) && (n <= e + ct[i])}, 32'h1);
    end
    // Toggle flip-flop seen through the level bit, gate control off
    gate_pin <= 1'b0;
    // Let the pin settle low first, or the polarity change looks like a rising edge
    repeat (8) @(posedge clk);
    wr(`GT_OFF_GATE, 32'h06);
    rd(`GT_OFF_GATE);
    chk(rd_val, 32'h06);
    pin_pulse(1'b0);
    rd(`GT_OFF_GATE);
    chk(rd_val, 32'h26);
    pin_pulse(1'b0);
    rd(`GT_OFF_GATE);
    chk(rd_val, 32'h06);
    wr(`GT_OFF_GATE, 32'h02);
    gate_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`GT_OFF_GATE);
    chk(rd_val, 32'h22);
    // Compare trigger
    for (int u = 0; u < 2; u++)
    begin
      wr(`GT_OFF_COUNT, 32'h1234);
      trig_pulse(2'(1 << u));
      rd(`GT_OFF_COUNT);
      chk(rd_val, 32'h0);
    end
    rd(`GT_OFF_IRQ_STATUS);
    chk(rd_val, 32'h0);
    wr(`GT_OFF_COUNT, 32'h0055, 1'b1);
    rd(`GT_OFF_COUNT);
    chk(rd_val, 32'h0055);
    wr(`GT_OFF_CONTROL, 32'h2);
    wr(`GT_OFF_COUNT, 32'h0077);
    trig_pulse(2'b01);
    rd(`GT_OFF_COUNT);
    chk(rd_val, 32'h0077);
    cmp_mode <= 8'hBA;
    wr(`GT_OFF_CONTROL, 32'h4);
    trig_pulse(2'b01);
    rd(`GT_OFF_COUNT);
    chk(rd_val, 32'h0077);
    // External pin clock, synchronised
    wr(`GT_OFF_CONTROL, 32'h6);
    wr(`GT_OFF_COUNT, 32'h0);
    wr(`GT_OFF_CONTROL, 32'hE);
    repeat (5) pin_pulse(1'b1);
    wr(`GT_OFF_CONTROL, 32'h6);
    rd(`GT_OFF_COUNT);
    chk(rd_val, 32'h5);
    conclude();
  end
endmodule  // gated_sixteen_bit_timer_tb
